/* File: design/tsg_core.sv */
// Trip latching, first-out, trip history, relays, controlled stop,
// time-of-day sync and local/remote command gating behind APB3.
// Assumes contacts are asynchronous pins; serial commands and ramp
// status inputs come from logic on pclk.
//
// Notes on behaviour
// - Shutdown forces both valve outputs to zero and drops shutdown relays.
// - Ten trip contacts cause shutdown; ten alarm contacts only indicate.
// - First-out indication is latched; trip reset never clears it.
// - Keep last twenty trip entries; oldest dropped when full.
// - Trip relay copy mirrors the trip relay: energised, drops on shutdown.
// - Shutdown indication relay energises on shutdown until all trips clear.
// - Reset-clears-trip option also drops the shutdown indication relay.
// - Reject controlled stop under manual start without idle speeds.
// - Stop disables loops but speed/extraction, then extraction, couples map; here loops_off, extr_off, map_coupled all set at once in CS_DISABLE.
// - Then ramp speed setpoint to zero, then HP valve limiter to zero.
// - Stop ends in full shutdown and a controlled-stop message.
// - No automatic generator breaker open during controlled stop.
// - Start/abort from PC, contact or either serial port, no confirmation.
// - Controlled stop can be aborted at any step before completion.
// - Contact closure starts the stop, opening aborts it.
// - Serial start and stop are separate commands.
// - Time-sync closure loads hour, minute, second from preset.
// - Time-sync contact scanned each tick; load on rising edge.
// - Without local/remote, all contacts and configured serial are honoured.
// - Local mode ignores contacts and serial except the exempt ones.
// - Closed mode contact selects remote; remote honours all sources.
// - Per-source keep-in-local enables; local relay and remote status bit.
//
// Chosen here: the APB slave port and the placing of the registers.
`default_nettype none
module tsg_core
    import tsg_pkg::*;
#(
    parameter int SCAN_CYCLES = SCAN_CYC,
    parameter int SEC_CYCLES = SEC_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [tsg_pkg::NPIN-1:0] contact_in,
    input wire logic ser1_valid,
    input wire tsg_pkg::tsg_ser_cmd_t ser1_cmd,
    input wire logic ser2_valid,
    input wire tsg_pkg::tsg_ser_cmd_t ser2_cmd,
    input wire logic spd_at_zero,
    input wire logic hp_lim_at_zero,
    output logic [1:0] valve_zero,
    output logic trip_relay,
    output logic trip_mirror_relay,
    output logic sd_ind_relay,
    output logic local_relay,
    output logic remote_stat,
    output tsg_pkg::tsg_cs_out_t cs_out
);
    import tsg_pkg::*;

    typedef enum logic [2:0] {
        CS_IDLE, CS_DISABLE, CS_SPD, CS_HP, CS_DONE
    } tsg_cs_state_t;

    function automatic logic [3:0] lowest(input logic [NTRIP-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NTRIP - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] wrap20(input logic [5:0] v);
        logic [5:0] r;
        r = (v >= 6'(HIST_DEPTH)) ? v - 6'(HIST_DEPTH) : v;
        return r[4:0];
    endfunction

    // ----------------------------------------
    // Contact synchronisers and scan
    // ----------------------------------------
    logic [NPIN-1:0] s1_q, s2_q, s3_q, flt_q, scan_q, prev_q;
    logic [18:0] scan_cnt_q;
    logic tick_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            flt_q <= '0;
        end else if (ce) begin
            s1_q <= contact_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_cnt_q <= '0;
            tick_q <= 1'b0;
            scan_q <= '0;
            prev_q <= '0;
        end else if (ce) begin
            tick_q <= (scan_cnt_q == 19'(SCAN_CYCLES - 1));
            scan_cnt_q <= (scan_cnt_q == 19'(SCAN_CYCLES - 1)) ? '0
                : scan_cnt_q + 19'h1;
            if (tick_q) begin
                scan_q <= flt_q;
                prev_q <= scan_q;
            end
        end
    end

    // ----------------------------------------
    // Registers and command gating
    // ----------------------------------------
    logic [CTRL_W-1:0] ctrl_q;
    logic [NTRIP-1:0] trip_en_q;
    logic [NALM-1:0] alm_en_q;
    logic [4:0] hsel_q;
    tsg_tod_t tpre_q, tod_q;
    logic remote_q, trip_q, cs_msg_q, cs_rej_q, fo_valid_q;
    logic [3:0] fo_idx_q;
    tsg_cs_state_t cs_q, cs_d;
    logic wr_en, scan_new;
    logic [4:0] cmd;
    logic con_ok, s1_ok, s2_ok, s1_any, s2_any, lr_on;

    assign wr_en = psel & penable & pready & pwrite;
    assign cmd = (wr_en && paddr == OFS_CMD) ? pwdata[4:0] : 5'h00;
    assign scan_new = tick_q;
    assign s1_any = ser1_valid & ctrl_q[C_SER_CFG];
    assign s2_any = ser2_valid & ctrl_q[C_SER_CFG];
    assign lr_on = ctrl_q[C_LR_CFG];
    // Trip, alarm and mode contacts bypass these gates
    assign con_ok = !lr_on | remote_q | ctrl_q[C_KEEP_CON];
    assign s1_ok = s1_any & (!lr_on | remote_q | ctrl_q[C_KEEP_S1]);
    assign s2_ok = s2_any & (!lr_on | remote_q | ctrl_q[C_KEEP_S2]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            trip_en_q <= '0;
            alm_en_q <= '0;
            hsel_q <= '0;
            tpre_q <= '0;
        end else if (ce && wr_en) begin
            unique case (paddr)
                OFS_CTRL: ctrl_q <= pwdata[CTRL_W-1:0];
                OFS_CEN: begin
                    trip_en_q <= pwdata[NTRIP-1:0];
                    alm_en_q <= pwdata[CEN_ALM +: NALM];
                end
                OFS_HSEL: hsel_q <= pwdata[4:0];
                OFS_TPRE: tpre_q <= pwdata[16:0];
                default: ;
            endcase
        end
    end

    // Serial mode-select stays live in local mode; contact wins if chosen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_q <= 1'b1;
        end else if (ce) begin
            if (ctrl_q[C_LR_BY_CON]) begin
                remote_q <= scan_q[PIN_LR];
            end else if (cmd[K_REMOTE] | (s1_any & ser1_cmd.remote_sel)
                    | (s2_any & ser2_cmd.remote_sel)) begin
                remote_q <= 1'b1;
            end else if (cmd[K_LOCAL] | (s1_any & ser1_cmd.local_sel)
                    | (s2_any & ser2_cmd.local_sel)) begin
                remote_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Trip latch and relays
    // ----------------------------------------
    logic [NTRIP-1:0] trip_act, trip_rise;
    logic trip_set, trip_clr, trip_d;

    assign trip_act = scan_q[PIN_TRIP +: NTRIP] & trip_en_q;
    assign trip_rise = trip_act & ~prev_q[PIN_TRIP +: NTRIP];
    assign trip_set = |trip_act | (s1_any & ser1_cmd.trip)
        | (s2_any & ser2_cmd.trip) | (cs_q == CS_DONE);
    assign trip_clr = cmd[K_RESET] & ctrl_q[C_RST_CLR] & ~|trip_act;
    assign trip_d = trip_set | (trip_q & ~trip_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_q <= 1'b0;
            valve_zero <= 2'b00;
            trip_relay <= 1'b1;
            trip_mirror_relay <= 1'b1;
            sd_ind_relay <= 1'b0;
        end else if (ce) begin
            trip_q <= trip_d;
            valve_zero <= {2{trip_d}};
            trip_relay <= ~trip_d;
            trip_mirror_relay <= ~trip_d;
            // Held while any trip is latched or any enabled trip contact is closed
            sd_ind_relay <= trip_d | (|trip_act);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            local_relay <= 1'b0;
            remote_stat <= 1'b1;
        end else if (ce) begin
            local_relay <= lr_on & ~remote_q;
            remote_stat <= remote_q | ~lr_on;
        end
    end

    // ----------------------------------------
    // First-out and history
    // ----------------------------------------
    logic [NTRIP-1:0] pend_q;
    logic [3:0] hist_q [HIST_DEPTH];
    logic [4:0] wp_q, hcnt_q, rd_idx;
    logic [3:0] pend_lo;

    // Power-on reset only; the trip reset command has no path here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fo_valid_q <= 1'b0;
            fo_idx_q <= '0;
        end else if (ce && !trip_q && |trip_act) begin
            fo_valid_q <= 1'b1;
            fo_idx_q <= lowest(trip_act);
        end
    end

    assign pend_lo = lowest(pend_q);

    // One entry per cycle drains simultaneous trips in input order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= '0;
            wp_q <= '0;
            hcnt_q <= '0;
        end else if (ce) begin
            pend_q <= (scan_new ? trip_rise : '0)
                | (pend_q & ~(NTRIP'(1) << pend_lo));
            if (|pend_q) begin
                wp_q <= wrap20({1'b0, wp_q} + 6'h01);
                if (hcnt_q != 5'(HIST_DEPTH)) begin
                    hcnt_q <= hcnt_q + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (ce && |pend_q) begin
            hist_q[wp_q] <= pend_lo;
        end
    end

    // Entry zero is the newest
    assign rd_idx = wrap20({1'b0, wp_q} + 6'(HIST_DEPTH - 1)
        - {1'b0, hsel_q});

    // ----------------------------------------
    // Controlled stop
    // ----------------------------------------
    logic cs_start, cs_abort, cs_reject, con_cs;

    assign con_cs = scan_new & con_ok & ctrl_q[C_CSCON_EN];
    // No confirmation on contact or serial requests
    assign cs_start = cmd[K_CS_START]
        | (con_cs & scan_q[PIN_CSTOP] & ~prev_q[PIN_CSTOP])
        | (s1_ok & ser1_cmd.cs_start) | (s2_ok & ser2_cmd.cs_start);
    assign cs_abort = cmd[K_CS_ABORT]
        | (con_cs & ~scan_q[PIN_CSTOP] & prev_q[PIN_CSTOP])
        | (s1_ok & ser1_cmd.cs_stop) | (s2_ok & ser2_cmd.cs_stop);
    assign cs_reject = ctrl_q[C_MAN_START] & ~ctrl_q[C_IDLE_CFG];

    // Breaker stays with the plant: no open command is ever produced
    always_comb begin
        cs_d = cs_q;
        unique case (cs_q)
            CS_IDLE: begin
                if (cs_start && !cs_reject && !trip_q) begin
                    cs_d = CS_DISABLE;
                end
            end
            CS_DISABLE: cs_d = CS_SPD;
            CS_SPD: begin
                if (spd_at_zero) begin
                    cs_d = CS_HP;
                end
            end
            CS_HP: begin
                if (hp_lim_at_zero) begin
                    cs_d = CS_DONE;
                end
            end
            CS_DONE: cs_d = CS_IDLE;
            default: cs_d = CS_IDLE;
        endcase
        if (cs_q != CS_IDLE && cs_q != CS_DONE && (cs_abort || trip_q)) begin
            cs_d = CS_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_q <= CS_IDLE;
            cs_out <= '0;
        end else if (ce) begin
            cs_q <= cs_d;
            cs_out.loops_off <= cs_d != CS_IDLE;
            cs_out.extr_off <= cs_d != CS_IDLE;
            cs_out.lp_lim_max <= cs_d != CS_IDLE;
            cs_out.map_coupled <= cs_d != CS_IDLE;
            cs_out.spd_ramp <= cs_d == CS_SPD || cs_d == CS_HP;
            cs_out.hp_ramp <= cs_d == CS_HP;
        end
    end

    // Message and reject flag: set wins over reset command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_msg_q <= 1'b0;
            cs_rej_q <= 1'b0;
        end else if (ce) begin
            cs_msg_q <= (cs_q == CS_DONE) | (cs_msg_q & ~cmd[K_RESET]);
            cs_rej_q <= ((cs_q == CS_IDLE) & cs_start & cs_reject)
                | (cs_rej_q & ~cmd[K_RESET]);
        end
    end

    // ----------------------------------------
    // Time of day
    // ----------------------------------------
    logic [25:0] sec_cnt_q;
    logic tsync_load;

    assign tsync_load = scan_new & ctrl_q[C_TSYNC_EN] & con_ok
        & scan_q[PIN_TSYNC] & ~prev_q[PIN_TSYNC];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt_q <= '0;
            tod_q <= '0;
        end else if (ce) begin
            if (tsync_load) begin
                sec_cnt_q <= '0;
                tod_q <= tpre_q;
            end else if (sec_cnt_q == 26'(SEC_CYCLES - 1)) begin
                sec_cnt_q <= '0;
                tod_q.ss <= (tod_q.ss == 6'd59) ? 6'd0 : tod_q.ss + 6'd1;
                if (tod_q.ss == 6'd59) begin
                    tod_q.mm <= (tod_q.mm == 6'd59) ? 6'd0 : tod_q.mm + 6'd1;
                    if (tod_q.mm == 6'd59) begin
                        tod_q.hh <= (tod_q.hh == 5'd23) ? 5'd0
                            : tod_q.hh + 5'd1;
                    end
                end
            end else begin
                sec_cnt_q <= sec_cnt_q + 26'h1;
            end
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    logic [31:0] rd_d;
    logic map_hit;

    always_comb begin
        rd_d = 32'h0;
        map_hit = 1'b1;
        unique case (paddr)
            OFS_CTRL: rd_d[CTRL_W-1:0] = ctrl_q;
            OFS_CEN: rd_d = {6'h0, alm_en_q, 6'h0, trip_en_q};
            OFS_CMD: rd_d = 32'h0;
            OFS_STAT: rd_d = {6'h0, scan_q[PIN_ALM +: NALM] & alm_en_q, 9'h0,
                cs_rej_q, cs_msg_q, cs_q != CS_IDLE, local_relay,
                remote_stat, sd_ind_relay, trip_q};
            OFS_FOUT: rd_d = {23'h0, fo_valid_q, 4'h0, fo_idx_q};
            OFS_HSEL: rd_d = {27'h0, hsel_q};
            OFS_HDAT: rd_d = {19'h0, hcnt_q, 4'h0,
                (hsel_q < hcnt_q) ? hist_q[rd_idx] : 4'h0};
            OFS_TPRE: rd_d = {15'h0, tpre_q};
            OFS_TOD: rd_d = {15'h0, tod_q};
            default: map_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel & penable & ~pready;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h0 : rd_d;
                pslverr <= ~map_hit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_valve_force_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ce && trip_set |=> valve_zero == 2'b11 && !trip_relay)
        else $error("valves not forced to zero on trip");
    a_mirror_relay_match: assert property (@(posedge pclk)
        disable iff (!presetn) trip_mirror_relay == trip_relay)
        else $error("trip relay copy differs");
    a_sd_ind_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ce && sd_ind_relay && |trip_act |=> sd_ind_relay)
        else $error("shutdown indication dropped with trip active");
    a_first_out_stable: assert property (@(posedge pclk)
        disable iff (!presetn)
        fo_valid_q && trip_q |=> $stable(fo_idx_q) && fo_valid_q)
        else $error("first-out changed while latched");
    a_hist_count_max: assert property (@(posedge pclk) disable iff (!presetn)
        hcnt_q <= 5'(HIST_DEPTH) && wp_q < 5'(HIST_DEPTH))
        else $error("history pointer out of range");
    a_cstop_reject: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cs_q == CS_IDLE && cs_reject |=> cs_q == CS_IDLE)
        else $error("controlled stop started while not allowed");
    a_cstop_end_trip: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cs_q == CS_HP && hp_lim_at_zero && !cs_abort && !trip_q
        ##1 ce |=> trip_q && cs_msg_q && valve_zero == 2'b11)
        else $error("controlled stop did not end in shutdown");
    a_cstop_abort: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cs_abort && cs_q inside {CS_DISABLE, CS_SPD, CS_HP}
        |=> cs_q == CS_IDLE && cs_out == '0)
        else $error("abort not honoured");
    a_tsync_load: assert property (@(posedge pclk) disable iff (!presetn)
        ce && tsync_load |=> tod_q == $past(tpre_q))
        else $error("time-of-day not loaded from preset");
    a_local_relay: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> local_relay == ($past(lr_on) && !$past(remote_q)))
        else $error("local relay wrong");
endmodule
`default_nettype wire

/* File: pkg/tsg_pkg.sv */
// Shared constants and types of the turbine shutdown and command gating block.
// Assumes a single 40 MHz clock and an APB3 register port.
`default_nettype none
package tsg_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int SCAN_MS = 10;
    localparam int SCAN_CYC = CLK_HZ / 1000 * SCAN_MS;
    localparam int SEC_CYC = CLK_HZ;
    // ----------------------------------------
    // Contacts and history
    // ----------------------------------------
    localparam int NTRIP = 10;
    localparam int NALM = 10;
    localparam int HIST_DEPTH = 20;
    localparam int PIN_TRIP = 0;
    localparam int PIN_ALM = 10;
    localparam int PIN_CSTOP = 20;
    localparam int PIN_TSYNC = 21;
    localparam int PIN_LR = 22;
    localparam int NPIN = 23;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CEN = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_FOUT = 8'h10;
    localparam logic [7:0] OFS_HSEL = 8'h14;
    localparam logic [7:0] OFS_HDAT = 8'h18;
    localparam logic [7:0] OFS_TPRE = 8'h1c;
    localparam logic [7:0] OFS_TOD = 8'h20;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int C_LR_CFG = 0;
    localparam int C_KEEP_CON = 1;
    localparam int C_KEEP_S1 = 2;
    localparam int C_KEEP_S2 = 3;
    localparam int C_LR_BY_CON = 4;
    localparam int C_MAN_START = 5;
    localparam int C_IDLE_CFG = 6;
    localparam int C_SER_CFG = 7;
    localparam int C_TSYNC_EN = 8;
    localparam int C_CSCON_EN = 9;
    localparam int C_RST_CLR = 10;
    localparam int CTRL_W = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
    localparam int CEN_ALM = 16;
    localparam int K_CS_START = 0;
    localparam int K_CS_ABORT = 1;
    localparam int K_RESET = 2;
    localparam int K_LOCAL = 3;
    localparam int K_REMOTE = 4;
    localparam int FO_VALID = 8;
    localparam int HD_CNT = 8;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic trip;
        logic local_sel;
        logic remote_sel;
        logic cs_stop;
        logic cs_start;
    } tsg_ser_cmd_t;
    typedef struct packed {
        logic [4:0] hh;
        logic [5:0] mm;
        logic [5:0] ss;
    } tsg_tod_t;
    typedef struct packed {
        logic loops_off;
        logic extr_off;
        logic lp_lim_max;
        logic map_coupled;
        logic spd_ramp;
        logic hp_ramp;
    } tsg_cs_out_t;
endpackage
`default_nettype wire

/* File: test/tsg_core_tb.sv */
// Self-checking bench for tsg_core over APB with the plant model.
// Assumes short scan count; ce held high.
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tsg_core_tb
    import tsg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, e, trip_relay, trip_mirror_relay, sd_ind_relay;
    logic local_relay, remote_stat, ser1_valid, ser2_valid;
    logic spd_at_zero, hp_lim_at_zero;
    logic [1:0] valve_zero;
    logic [NPIN-1:0] contact_in;
    tsg_ser_cmd_t ser1_cmd, ser2_cmd;
    tsg_cs_out_t cs_out;
    int errors = 0, checked = 0, n;
    tsg_core #(.SCAN_CYCLES(8), .SEC_CYCLES(100000)) u_tsg_core (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .contact_in, .ser1_valid, .ser1_cmd,
        .ser2_valid, .ser2_cmd, .spd_at_zero, .hp_lim_at_zero, .valve_zero,
        .trip_relay, .trip_mirror_relay, .sd_ind_relay, .local_relay,
        .remote_stat, .cs_out);
    tsg_plant u_tsg_plant (.pclk, .cs_out, .contact_in, .ser1_valid,
        .ser1_cmd, .ser2_valid, .ser2_cmd, .spd_at_zero, .hp_lim_at_zero);
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task tick(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task print_verdict;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial forever #12.5 pclk = ~pclk;
    // Run needs about 500 cycles; hang guard well beyond that
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        print_verdict();
    end
    initial begin
        tick(20);
        presetn <= 1'b1;
        tick(2);
        `CHK({valve_zero, trip_relay, sd_ind_relay, remote_stat}, 5'b00101)
        apb(1, OFS_CTRL, 32'h381);
        apb(1, OFS_CEN, 32'h3ff03ff);
        apb(0, OFS_CTRL, 0);
        `CHK(r, 32'h381)
        apb(0, 8'h40, 0);
        `CHK({e, r}, 33'h100000000)
        apb(1, OFS_TPRE, 32'hdb5e);
        u_tsg_plant.pins(23'h201000, 1'b1);
        tick(40);
        apb(0, OFS_TOD, 0);
        `CHK(r, 32'hdb5e)
        apb(0, OFS_STAT, 0);
        `CHK({r[18], r[0], trip_relay}, 3'b101)
        u_tsg_plant.pins(23'h201000, 1'b0);
        u_tsg_plant.send(1, 5'h01);
        tick(3);
        `CHK(cs_out, 6'h3e)
        u_tsg_plant.send(2, 5'h02);
        tick(3);
        `CHK(cs_out, 6'h00)
        u_tsg_plant.pins(23'h100000, 1'b1);
        tick(40);
        apb(0, OFS_STAT, 0);
        `CHK(r[4], 1'b1)
        u_tsg_plant.pins(23'h100000, 1'b0);
        tick(40);
        apb(0, OFS_STAT, 0);
        `CHK(r[4], 1'b0)
        u_tsg_plant.send(1, 5'h08);
        tick(2);
        `CHK({local_relay, remote_stat}, 2'b10)
        u_tsg_plant.send(1, 5'h01);
        u_tsg_plant.pins(23'h100000, 1'b1);
        tick(40);
        `CHK(cs_out, 6'h00)
        u_tsg_plant.pins(23'h100000, 1'b0);
        u_tsg_plant.pins(23'h28, 1'b1);
        tick(40);
        `CHK({valve_zero, trip_relay, trip_mirror_relay, sd_ind_relay}, 5'h19)
        apb(0, OFS_FOUT, 0);
        `CHK(r, 32'h103)
        apb(0, OFS_HDAT, 0);
        `CHK(r, 32'h205)
        u_tsg_plant.send(1, 5'h04);
        u_tsg_plant.pins(23'h28, 1'b0);
        tick(40);
        apb(1, OFS_CMD, 32'h4);
        tick(3);
        `CHK({trip_relay, sd_ind_relay}, 2'b01)
        apb(1, OFS_CTRL, 32'h781);
        apb(1, OFS_CMD, 32'h4);
        tick(3);
        `CHK({trip_mirror_relay, sd_ind_relay}, 2'b10)
        apb(0, OFS_FOUT, 0);
        `CHK(r, 32'h103)
        apb(1, OFS_CTRL, 32'h7a1);
        apb(1, OFS_CMD, 32'h1);
        apb(0, OFS_STAT, 0);
        `CHK(r[6:4], 3'b100)
        apb(1, OFS_CTRL, 32'h791);
        tick(3);
        `CHK({local_relay, remote_stat}, 2'b10)
        u_tsg_plant.pins(23'h400000, 1'b1);
        tick(40);
        `CHK({local_relay, remote_stat}, 2'b01)
        u_tsg_plant.pins(23'h400000, 1'b0);
        tick(40);
        apb(1, OFS_CTRL, 32'h799);
        u_tsg_plant.ramp_len = 3;
        u_tsg_plant.send(2, 5'h01);
        for (n = 0; n < 100 && valve_zero !== 2'b11; n++) @(posedge pclk);
        apb(0, OFS_STAT, 0);
        `CHK({valve_zero, trip_relay, r[5]}, 4'b1101)
        print_verdict();
    end
endmodule
`undef CHK
`default_nettype wire

/* File: test/tsg_plant.sv */
// Plant model: contact pins, two serial masters, ramp feedback.
// Assumes the bench calls its tasks; pclk is the core clock.
`default_nettype none
module tsg_plant
    import tsg_pkg::*;
(
    input wire logic pclk,
    input wire tsg_pkg::tsg_cs_out_t cs_out,
    output logic [tsg_pkg::NPIN-1:0] contact_in,
    output logic ser1_valid,
    output tsg_pkg::tsg_ser_cmd_t ser1_cmd,
    output logic ser2_valid,
    output tsg_pkg::tsg_ser_cmd_t ser2_cmd,
    output logic spd_at_zero,
    output logic hp_lim_at_zero
);
    timeunit 1ns;
    timeprecision 1ps;
    int ramp_len = 64;
    int spd_n = 0;
    int hp_n = 0;
    initial begin
        contact_in = '0;
        ser1_valid = 1'b0;
        ser2_valid = 1'b0;
        ser1_cmd = '0;
        ser2_cmd = '0;
    end
    // Slow actuators by default; bench shortens ramp_len for prompt
    always @(posedge pclk) begin
        spd_n <= cs_out.spd_ramp ? spd_n + 1 : 0;
        hp_n <= cs_out.hp_ramp ? hp_n + 1 : 0;
    end
    assign spd_at_zero = spd_n >= ramp_len;
    assign hp_lim_at_zero = hp_n >= ramp_len;
    // Contact held at level until told otherwise
    task pins(input logic [22:0] m, input logic v);
        @(posedge pclk);
        contact_in <= (contact_in & ~m) | (m & {NPIN{v}});
    endtask
    // One command per pulse; start and stop are distinct codes
    task send(input int p, input logic [4:0] c);
        @(posedge pclk);
        if (p == 1) begin
            ser1_valid <= 1'b1;
            ser1_cmd <= c;
        end else begin
            ser2_valid <= 1'b1;
            ser2_cmd <= c;
        end
        @(posedge pclk);
        ser1_valid <= 1'b0;
        ser2_valid <= 1'b0;
        // Released bus shows garbage, not the old command
        ser1_cmd <= ~ser1_cmd;
        ser2_cmd <= ~ser2_cmd;
    endtask
endmodule
`default_nettype wire
